// ==== rtl/ips_pkg.sv ====
// Purpose: shared constants and types of the port statistics responder
// Assumes: 32-bit register words, byte addresses, one 25 MHz clock
// Notes:   counter order matches the reply packet order
package ips_pkg;
   // counter bank shape
   localparam int CNT_NUM    = 15;
   localparam int CNT_W      = 64;
   localparam int SNAP_WORDS = 30;
   localparam int EVT_NUM    = 13;
   localparam int OCT_W      = 4;
   localparam int DIV_SHIFT  = 2;

   // counter indices, in reply order
   localparam int CNT_TX_DATA      = 0;
   localparam int CNT_RX_DATA      = 1;
   localparam int CNT_TX_PKT       = 2;
   localparam int CNT_RX_PKT       = 3;
   localparam int CNT_TX_WAIT      = 4;
   localparam int CNT_TX_DISCARD   = 5;
   localparam int CNT_LANE_ERR     = 6;
   localparam int CNT_RECOVERY     = 7;
   localparam int CNT_LINK_DOWN    = 8;
   localparam int CNT_RX_ERR       = 9;
   localparam int CNT_BAD_DELIM    = 10;
   localparam int CNT_RELAY_DROP   = 11;
   localparam int CNT_INTEGRITY    = 12;
   localparam int CNT_OVERRUN      = 13;
   localparam int CNT_MGMT_DROP    = 14;

   // command and reply codes
   localparam logic [7:0]  CMD_STATS      = 8'h66;
   localparam logic [7:0]  REPLY_STATS    = 8'hE6;
   localparam logic [7:0]  REPLY_FLAG     = 8'h80;
   localparam logic [15:0] RESP_OK        = 16'h0000;
   localparam logic [15:0] RESP_FAIL      = 16'h0001;
   localparam logic [15:0] REASON_NONE    = 16'h0000;
   localparam logic [15:0] REASON_UNSUPP  = 16'h7FFF;

   // packet byte positions
   localparam int PKT_HDR_BYTES  = 16;
   localparam int CMD_CSUM_BYTE  = 16;
   localparam int CMD_PAD_END    = 45;
   localparam int RSP_CODE_BYTE  = 16;
   localparam int RSP_CNT_BYTE   = 28;
   localparam int RSP_CSUM_BYTE  = 148;

   // link type and state encodings
   localparam logic LINK_ETH    = 1'b0;
   localparam logic LINK_FABRIC = 1'b1;
   typedef enum logic [2:0] {
      PS_ETH    = 3'h0,
      PS_DOWN   = 3'h1,
      PS_INIT   = 3'h2,
      PS_ARM    = 3'h3,
      PS_ACTIVE = 3'h4
   } ips_port_state_t;
   typedef enum logic [2:0] {
      SPD_SDR   = 3'h0,
      SPD_DDR   = 3'h1,
      SPD_QDR   = 3'h2,
      SPD_FDR10 = 3'h3,
      SPD_FDR   = 3'h4,
      SPD_EDR   = 3'h5,
      SPD_HDR   = 3'h6,
      SPD_NDR   = 3'h7
   } ips_speed_t;
   localparam logic [7:0] SPEED_NONE = 8'h00;

   // register offsets (byte addresses)
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  OFF_CMD         = 8'h00;
   localparam logic [7:0]  OFF_REPLY_TYPE  = 8'h04;
   localparam logic [7:0]  OFF_REPLY_CODE  = 8'h08;
   localparam logic [7:0]  OFF_LINK        = 8'h0C;
   localparam logic [7:0]  OFF_INT_STATUS  = 8'h10;
   localparam logic [7:0]  OFF_INT_CLEAR   = 8'h14;
   localparam logic [7:0]  OFF_INT_ENABLE  = 8'h18;
   localparam logic [7:0]  OFF_REPLY_STAT  = 8'h1C;
   localparam logic [7:0]  OFF_SNAP_BASE   = 8'h40;
   localparam logic [7:0]  OFF_SNAP_LAST   = 8'hB4;

   // field positions
   localparam int CMD_CODE_LSB   = 0;
   localparam int CMD_CSUM_BIT   = 8;
   localparam int CMD_ID_BIT     = 9;
   localparam int LINK_LOG_LSB   = 0;
   localparam int LINK_ACT_LSB   = 8;
   localparam int LINK_SUP_LSB   = 16;
   localparam int LINK_TYPE_BIT  = 24;
   localparam int STAT_PEND_BIT  = 0;
   localparam int STAT_DROP_LSB  = 8;
   localparam int INT_W          = 3;
   localparam int INT_REPLY      = 0;
   localparam int INT_DROP       = 1;
   localparam int INT_UNSUP      = 2;

   // reset values
   localparam logic [31:0]      WORD_RST   = 32'h0000_0000;
   localparam logic [INT_W-1:0] INT_RST    = 3'h0;
   localparam logic [7:0]       DROP_RST   = 8'h00;

   typedef enum logic {
      BUS_ANSWER = 1'b0,
      BUS_WAIT   = 1'b1
   } ips_bus_t;
endpackage

// ==== rtl/ips_cnt_if.sv ====
// Purpose: carrier between the responder and its counter bank
// Assumes: all signals on core_clk
// Notes:   counters 0 and 1 use the octet inputs, the rest use inc
`timescale 1ns/1ns
interface ips_cnt_if;
   logic [ips_pkg::OCT_W-1:0]   tx_octets;
   logic [ips_pkg::OCT_W-1:0]   rx_octets;
   logic [ips_pkg::EVT_NUM-1:0] inc;
   logic [ips_pkg::CNT_W-1:0]   count [ips_pkg::CNT_NUM];
   modport bank (input tx_octets, input rx_octets, input inc, output count);
   modport user (output tx_octets, output rx_octets, output inc, input count);
endinterface

// ==== rtl/ips_counter_bank.sv ====
// Purpose: fifteen free-running 64-bit port statistics counters
// Assumes: event and octet inputs are same-clock logic
// Notes:   counters wrap; only reset clears them
`timescale 1ns/1ns
module ips_counter_bank (
   input  wire logic  core_clk,
   input  wire logic  rst_n,
   ips_cnt_if.bank    cnt
);
   for (genvar i = 0; i < ips_pkg::CNT_NUM; i++) begin : g_cnt
      logic [ips_pkg::CNT_W-1:0] count_r;
      assign cnt.count[i] = count_r;
      if (i <= ips_pkg::CNT_RX_DATA) begin : g_data
         logic [ips_pkg::DIV_SHIFT-1:0] rem_r;
         logic [ips_pkg::OCT_W:0]       sum;
         // remainder kept so octets are not lost between cycles
         assign sum = {1'b0, (i == ips_pkg::CNT_TX_DATA) ? cnt.tx_octets : cnt.rx_octets}
                      + {{(ips_pkg::OCT_W - 1){1'b0}}, rem_r};
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               count_r <= '0;
               rem_r   <= '0;
            end else begin
               count_r <= count_r + {{(ips_pkg::CNT_W - 3){1'b0}},
                                     sum[ips_pkg::OCT_W:ips_pkg::DIV_SHIFT]};
               rem_r   <= sum[ips_pkg::DIV_SHIFT-1:0];
            end
         end
      end else begin : g_evt
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               count_r <= '0;
            end else if (cnt.inc[i-2]) begin
               count_r <= count_r + 64'h0000_0000_0000_0001;
            end
         end
      end
   end
endmodule

// ==== rtl/ips_port_stats_responder.sv ====
// Purpose: decode of the port statistics query, counter snapshot and link status
// Assumes: Avalon-MM slave with waitrequest, one answer cycle per access
// Notes:   the packet engine posts the command byte and check results here
`timescale 1ns/1ns
module ips_port_stats_responder #(
   parameter bit FABRIC_SUPPORTED = 1'b1
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             irq,
   input  wire logic        link_type,
   input  wire logic        link_up,
   input  wire logic [2:0]  port_state,
   input  wire logic [2:0]  active_speed_idx,
   input  wire logic [7:0]  supported_speed_bitmap,
   input  wire logic [3:0]  tx_octets,
   input  wire logic [3:0]  rx_octets,
   input  wire logic [12:0] count_events
);
   ips_cnt_if cnt ();

   ips_pkg::ips_bus_t                  bus_st_r;
   logic [31:0]                        rdata_r;
   logic                               irq_r;
   logic [7:0]                         reply_type_r;
   logic [31:0]                        reply_code_r;
   logic [31:0]                        link_r;
   logic [ips_pkg::INT_W-1:0]          int_status_r;
   logic [ips_pkg::INT_W-1:0]          int_status_nxt;
   logic [ips_pkg::INT_W-1:0]          int_en_r;
   logic [ips_pkg::INT_W-1:0]          int_evt;
   logic                               pend_r;
   logic [7:0]                         drop_cnt_r;
   logic [31:0]                        snap_r [ips_pkg::SNAP_WORDS];
   logic                               req;
   logic                               wr_fire;
   logic [31:0]                        wdata;
   logic                               cmd_fire;
   logic                               cmd_bad;
   logic                               cmd_ok_stats;
   logic                               cmd_unsupp;
   logic [7:0]                         cmd_code;
   logic [7:0]                         active_bits;
   logic [7:0]                         supported_bits;
   logic [2:0]                         log_state;

   ips_counter_bank u_bank (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .cnt      (cnt)
   );

   assign cnt.tx_octets = tx_octets;
   assign cnt.rx_octets = rx_octets;
   assign cnt.inc       = count_events;

   function automatic logic is_snap(input logic [7:0] a);
      return (a >= ips_pkg::OFF_SNAP_BASE) && (a <= ips_pkg::OFF_SNAP_LAST);
   endfunction

   // word index into the snapshot; low address bits are ignored
   function automatic logic [4:0] snap_word(input logic [7:0] a);
      logic [7:0] ofs;
      ofs = a - ips_pkg::OFF_SNAP_BASE;
      return ofs[6:2];
   endfunction

   function automatic logic is_stats_query(input logic [7:0] code);
      return (code == ips_pkg::CMD_STATS) && FABRIC_SUPPORTED;
   endfunction

   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return res;
   endfunction

   // bus handshake: one wait cycle, then answer; acts only on the answer edge
   assign req     = avs_read || avs_write;
   assign wr_fire = avs_write && (bus_st_r == ips_pkg::BUS_ANSWER);
   assign wdata   = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bus_st_r <= ips_pkg::BUS_WAIT;
      end else if (bus_st_r == ips_pkg::BUS_ANSWER) begin
         bus_st_r <= ips_pkg::BUS_WAIT;
      end else if (req) begin
         bus_st_r <= ips_pkg::BUS_ANSWER;
      end
   end
   assign avs_waitrequest = bus_st_r;

   // command decode; the requester builds the packet, only checks arrive here
   assign cmd_fire     = wr_fire && (avs_address == ips_pkg::OFF_CMD) && avs_byteenable[0];
   assign cmd_code     = avs_writedata[ips_pkg::CMD_CODE_LSB +: 8];
   assign cmd_bad      = avs_writedata[ips_pkg::CMD_CSUM_BIT]
                         || avs_writedata[ips_pkg::CMD_ID_BIT];
   assign cmd_ok_stats = cmd_fire && !cmd_bad && is_stats_query(cmd_code);
   assign cmd_unsupp   = cmd_fire && !cmd_bad && !is_stats_query(cmd_code);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reply_type_r <= 8'h00;
         reply_code_r <= ips_pkg::WORD_RST;
      end else if (cmd_ok_stats) begin
         reply_type_r <= ips_pkg::REPLY_STATS;
         reply_code_r <= {ips_pkg::RESP_OK, ips_pkg::REASON_NONE};
      end else if (cmd_unsupp) begin
         reply_type_r <= cmd_code | ips_pkg::REPLY_FLAG;
         reply_code_r <= {ips_pkg::RESP_FAIL, ips_pkg::REASON_UNSUPP};
      end
   end

   // one-edge copy keeps upper and lower halves coherent; counters untouched
   for (genvar i = 0; i < ips_pkg::CNT_NUM; i++) begin : g_snap
      always_ff @(posedge core_clk) begin
         if (!rst_n) begin
            snap_r[2*i]   <= ips_pkg::WORD_RST;
            snap_r[2*i+1] <= ips_pkg::WORD_RST;
         end else if (cmd_ok_stats) begin
            snap_r[2*i]   <= cnt.count[i][63:32];
            snap_r[2*i+1] <= cnt.count[i][31:0];
         end
      end
   end

   // reply pending flag: a new command beats the software clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pend_r <= 1'b0;
      end else if (cmd_fire && !cmd_bad) begin
         pend_r <= 1'b1;
      end else if (wr_fire && (avs_address == ips_pkg::OFF_REPLY_STAT)
                   && wdata[ips_pkg::STAT_PEND_BIT]) begin
         pend_r <= 1'b0;
      end
   end

   // count of silently dropped queries, wraps at 8 bits
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         drop_cnt_r <= ips_pkg::DROP_RST;
      end else if (cmd_fire && cmd_bad) begin
         drop_cnt_r <= drop_cnt_r + 8'h01;
      end
   end

   // link status fields
   always_comb begin
      active_bits    = ips_pkg::SPEED_NONE;
      supported_bits = ips_pkg::SPEED_NONE;
      log_state      = ips_pkg::PS_ETH;
      if (link_type == ips_pkg::LINK_FABRIC) begin
         supported_bits = supported_speed_bitmap;
         log_state      = port_state;
         if (link_up) begin
            active_bits = 8'h01 << active_speed_idx;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         link_r <= ips_pkg::WORD_RST;
      end else begin
         link_r <= ips_pkg::WORD_RST;
         link_r[ips_pkg::LINK_LOG_LSB +: 3] <= log_state;
         link_r[ips_pkg::LINK_ACT_LSB +: 8] <= active_bits;
         link_r[ips_pkg::LINK_SUP_LSB +: 8] <= supported_bits;
         link_r[ips_pkg::LINK_TYPE_BIT]     <= link_type;
      end
   end

   // interrupts: set beats clear in the same cycle
   always_comb begin
      int_evt                    = '0;
      int_evt[ips_pkg::INT_REPLY] = cmd_fire && !cmd_bad;
      int_evt[ips_pkg::INT_DROP]  = cmd_fire && cmd_bad;
      int_evt[ips_pkg::INT_UNSUP] = cmd_unsupp;
      int_status_nxt = int_status_r;
      if (wr_fire && (avs_address == ips_pkg::OFF_INT_CLEAR)) begin
         int_status_nxt = int_status_nxt & ~wdata[ips_pkg::INT_W-1:0];
      end
      int_status_nxt = int_status_nxt | int_evt;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         int_status_r <= ips_pkg::INT_RST;
      end else begin
         int_status_r <= int_status_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         int_en_r <= ips_pkg::INT_RST;
      end else if (wr_fire && (avs_address == ips_pkg::OFF_INT_ENABLE)
                   && avs_byteenable[0]) begin
         int_en_r <= avs_writedata[ips_pkg::INT_W-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(int_status_r & int_en_r);
      end
   end
   assign irq = irq_r;

   // read data registered in the wait cycle, stands on the answer edge
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_r <= ips_pkg::WORD_RST;
      end else if (req && (bus_st_r == ips_pkg::BUS_WAIT)) begin
         rdata_r <= ips_pkg::WORD_RST;
         if (avs_read) begin
            if (is_snap(avs_address)) begin
               rdata_r <= snap_r[snap_word(avs_address)];
            end else begin
               case (avs_address)
                  ips_pkg::OFF_REPLY_TYPE: rdata_r <= {24'h0, reply_type_r};
                  ips_pkg::OFF_REPLY_CODE: rdata_r <= reply_code_r;
                  ips_pkg::OFF_LINK:       rdata_r <= link_r;
                  ips_pkg::OFF_INT_STATUS: rdata_r <= {29'h0, int_status_r};
                  ips_pkg::OFF_INT_ENABLE: rdata_r <= {29'h0, int_en_r};
                  ips_pkg::OFF_REPLY_STAT: rdata_r <= {16'h0, drop_cnt_r, 7'h0, pend_r};
                  default:                 rdata_r <= ips_pkg::WORD_RST;
               endcase
            end
         end
      end
   end
   assign avs_readdata = rdata_r;
endmodule

// ==== testbench/ips_port_stats_responder_properties.sv ====
// Purpose: bus timing and field relations of the statistics responder
// Assumes: one clock, synchronous active-low reset
// Notes:   link fields are checked only once the inputs have rested seven cycles
`timescale 1ns/1ns
module ips_port_stats_responder_properties #(
   parameter bit FABRIC_SUPPORTED = 1'b1
) (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        irq,
   input wire logic        link_type,
   input wire logic        link_up,
   input wire logic [2:0]  port_state,
   input wire logic [2:0]  active_speed_idx,
   input wire logic [7:0]  supported_speed_bitmap
);
   logic [15:0] lnk;
   logic [15:0] lnk_r;
   logic [2:0]  quiet_r;
   logic [7:0]  code_r;
   logic        good_r;
   logic        ans;
   logic        lk;
   assign lnk = {link_type, link_up, port_state, active_speed_idx, supported_speed_bitmap};
   assign ans = avs_read && !avs_waitrequest;
   assign lk  = ans && avs_address == ips_pkg::OFF_LINK && quiet_r == 3'h7;
   // the link register lags its inputs, so wait until they rest
   always_ff @(posedge core_clk) begin
      lnk_r <= lnk;
      if (!rst_n || lnk_r != lnk)
         quiet_r <= 3'h0;
      else if (quiet_r != 3'h7)
         quiet_r <= quiet_r + 3'h1;
   end
   // last command that passed its checks
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         good_r <= 1'b0;
      else if (avs_write && !avs_waitrequest && avs_address == ips_pkg::OFF_CMD
               && avs_byteenable[0] && avs_writedata[9:8] == 2'b00) begin
         good_r <= 1'b1;
         code_r <= avs_writedata[7:0];
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   chk_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("no answer one cycle after request");
   chk_single_answer: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer held longer than one cycle");
   chk_reset_quiet: assert property (disable iff (1'b0) !rst_n
      |=> avs_waitrequest && avs_readdata == 32'h0000_0000 && !irq)
      else $error("outputs not quiet in reset");
   chk_log_state: assert property (lk |->
      avs_readdata[2:0] == (link_type ? port_state : 3'h0)) else $error("bad logical state");
   chk_active_speed: assert property (lk |-> avs_readdata[15:8] ==
      ((link_type && link_up) ? 8'h01 << active_speed_idx : 8'h00))
      else $error("bad active speed");
   chk_supported_speed: assert property (lk |-> avs_readdata[23:16] ==
      (link_type ? supported_speed_bitmap : 8'h00)) else $error("bad supported speed");
   chk_link_type_bit: assert property (lk |-> avs_readdata[24] == link_type)
      else $error("bad link type bit");
   chk_reply_type: assert property (ans && avs_address == ips_pkg::OFF_REPLY_TYPE
      && good_r |-> avs_readdata[7:0] == ((code_r == ips_pkg::CMD_STATS && FABRIC_SUPPORTED)
      ? ips_pkg::REPLY_STATS : code_r | ips_pkg::REPLY_FLAG)) else $error("bad reply type");
   chk_reply_ok: assert property (ans && avs_address == ips_pkg::OFF_REPLY_CODE && good_r
      && code_r == ips_pkg::CMD_STATS && FABRIC_SUPPORTED |-> avs_readdata == 32'h0000_0000)
      else $error("statistics query not answered as success");
endmodule
bind ips_port_stats_responder ips_port_stats_responder_properties
   #(.FABRIC_SUPPORTED(FABRIC_SUPPORTED)) chk (.*);

// ==== testbench/ips_mgmt_host.sv ====
// Purpose: management controller model driving the register bus
// Assumes: slave answers with waitrequest low, no fixed latency assumed
// Notes:   released address and data are inverted so stale values are not trusted
`timescale 1ns/1ns
module ips_mgmt_host (
   input  wire logic        core_clk,
   output logic      [7:0]  avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic      [31:0] avs_writedata,
   output logic      [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   initial begin
      avs_address    = 8'h00;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h0000_0000;
      avs_byteenable = 4'h0;
   end
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
      repeat ($urandom % 3) @(posedge core_clk);
      @(posedge core_clk);
      avs_address    <= a;
      avs_read       <= !w;
      avs_write      <= w;
      avs_writedata  <= d;
      avs_byteenable <= 4'hF;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read       <= 1'b0;
      avs_write      <= 1'b0;
      avs_address    <= ~a;
      avs_writedata  <= ~d;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(a, 1'b1, d, x);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(a, 1'b0, 32'h0000_0000, q);
   endtask
   // check flags stand for a failed checksum or identifier
   task automatic stats_query(input logic [1:0] bad);
      wr(ips_pkg::OFF_CMD, {22'h0, bad, ips_pkg::CMD_STATS});
   endtask
endmodule

// ==== testbench/ips_port_stats_responder_tb.sv ====
// Purpose: self-checking bench of the port statistics responder
// Assumes: 25 MHz clock, the host model drives the register bus
// Notes:   integer model of the counters; traffic stops before each query
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("unexpected %0t got %h exp %h", $time, g, e); end end
module ips_port_stats_responder_tb;
   logic            core_clk = 1'b0;
   logic            rst_n    = 1'b0;
   logic [7:0]      avs_address;
   logic            avs_read;
   logic            avs_write;
   logic [31:0]     avs_writedata;
   logic [3:0]      avs_byteenable;
   logic [31:0]     avs_readdata;
   logic            avs_waitrequest;
   logic            irq;
   logic            link_type = 1'b0;
   logic            link_up   = 1'b0;
   logic [2:0]      port_state = 3'h0;
   logic [2:0]      active_speed_idx = 3'h0;
   logic [7:0]      supported_speed_bitmap = 8'h00;
   logic [3:0]      tx_octets = 4'h0;
   logic [3:0]      rx_octets = 4'h0;
   logic [12:0]     count_events = 13'h0000;
   logic [31:0]     q;
   longint unsigned cnt [15];
   longint unsigned snap [15];
   int              rem_tx, rem_rx, drops, cycles, mismatches, num_checks;
   always #20 core_clk = ~core_clk;
   ips_port_stats_responder DUT (.*);
   ips_mgmt_host host (.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic reset_model();
      foreach (cnt[i]) cnt[i] = 0;
      snap = cnt;
      rem_tx = 0;
      rem_rx = 0;
      drops = 0;
   endtask
   task automatic traffic(input int n);
      logic [3:0]  t, r;
      logic [12:0] e;
      repeat (n) begin
         @(posedge core_clk);
         t = 4'($urandom);
         r = 4'($urandom);
         e = 13'($urandom);
         tx_octets <= t;
         rx_octets <= r;
         count_events <= e;
         rem_tx += t;
         rem_rx += r;
         cnt[0] += rem_tx / 4;
         cnt[1] += rem_rx / 4;
         rem_tx = rem_tx % 4;
         rem_rx = rem_rx % 4;
         for (int k = 0; k < 13; k++) cnt[k + 2] += e[k];
      end
      @(posedge core_clk);
      tx_octets <= 4'h0;
      rx_octets <= 4'h0;
      count_events <= 13'h0000;
   endtask
   task automatic good_query();
      host.stats_query(2'b00);
      snap = cnt;
   endtask
   task automatic check_snap();
      for (int n = 0; n < 15; n++) begin
         host.rd(8'(ips_pkg::OFF_SNAP_BASE + 8 * n), q);
         `CHK(q, snap[n][63:32])
         host.rd(8'(ips_pkg::OFF_SNAP_BASE + 8 * n + 4), q);
         `CHK(q, snap[n][31:0])
      end
   endtask
   task automatic irq_is(input logic v);
      repeat (2) @(negedge core_clk);
      `CHK(irq, v)
   endtask
   // a hang ends the run as a failure
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(32'hF85B));
      reset_model();
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      host.rd(8'hFC, q);
      `CHK(q, 32'h0000_0000)
      for (int i = 0; i < 16; i++) begin
         @(posedge core_clk);
         link_type <= i[2];
         link_up <= i[3];
         port_state <= 3'(i % 4 + 1);
         active_speed_idx <= 3'($urandom);
         supported_speed_bitmap <= 8'($urandom);
         repeat (8) @(posedge core_clk);
         host.rd(ips_pkg::OFF_LINK, q);
         `CHK(q[2:0], i[2] ? port_state : 3'h0)
         `CHK(q[15:8], (i[2] && i[3]) ? 8'h01 << active_speed_idx : 8'h00)
         `CHK(q[23:16], i[2] ? supported_speed_bitmap : 8'h00)
         `CHK(q[24], link_type)
      end
      host.wr(ips_pkg::OFF_INT_ENABLE, 32'h1);
      traffic(200);
      good_query();
      irq_is(1'b1);
      host.rd(ips_pkg::OFF_REPLY_TYPE, q);
      `CHK(q[7:0], ips_pkg::REPLY_STATS)
      host.rd(ips_pkg::OFF_REPLY_CODE, q);
      `CHK(q, {ips_pkg::RESP_OK, ips_pkg::REASON_NONE})
      check_snap();
      check_snap();
      traffic(100);
      good_query();
      check_snap();
      // failed checks leave the snapshot alone even with counters moving
      for (int b = 1; b < 4; b++) begin
         traffic(20);
         host.stats_query(2'(b));
         drops++;
      end
      host.rd(ips_pkg::OFF_REPLY_STAT, q);
      `CHK(q[15:8], 8'(drops))
      `CHK(q[0], 1'b1)
      host.rd(ips_pkg::OFF_INT_STATUS, q);
      `CHK(q[2:0], 3'h3)
      check_snap();
      host.wr(ips_pkg::OFF_INT_CLEAR, 32'h7);
      irq_is(1'b0);
      host.wr(ips_pkg::OFF_REPLY_STAT, 32'h1);
      host.rd(ips_pkg::OFF_REPLY_STAT, q);
      `CHK(q, {16'h0000, 8'(drops), 8'h00})
      host.wr(ips_pkg::OFF_INT_ENABLE, 32'h0);
      host.wr(ips_pkg::OFF_CMD, 32'h65);
      irq_is(1'b0);
      host.rd(ips_pkg::OFF_INT_STATUS, q);
      `CHK(q[2:0], 3'h5)
      host.rd(ips_pkg::OFF_REPLY_TYPE, q);
      `CHK(q[7:0], 8'hE5)
      host.rd(ips_pkg::OFF_REPLY_CODE, q);
      `CHK(q, {ips_pkg::RESP_FAIL, ips_pkg::REASON_UNSUPP})
      host.wr(ips_pkg::OFF_INT_ENABLE, 32'h4);
      irq_is(1'b1);
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      reset_model();
      traffic(30);
      good_query();
      check_snap();
      host.rd(ips_pkg::OFF_REPLY_STAT, q);
      `CHK(q, 32'h0000_0001)
      wrap_up();
   end
endmodule
